// ### srx_defines.svh
// Constants for the subtract, rotate and swap execution block.
// Assumes inclusion by the package and the modules of this block only.
`ifndef SRX_DEFINES_SVH
`define SRX_DEFINES_SVH
`define SRX_DATA_W     8
`define SRX_ADDR_W     7
`define SRX_NIB_LO     3
`define SRX_NIB_HI     4
`define SRX_MSB        7
`define SRX_DEST_ACC   1'b0
`define SRX_DEST_REG   1'b1
`define SRX_ZERO8      8'h00
`define SRX_WDT_W      16
`define SRX_PRE_W      8
`endif

// ### srx_pkg.sv
// Types for the subtract, rotate and swap execution block.
// Assumes srx_defines.svh sits in the include path.
`include "srx_defines.svh"
package srx_pkg;
  typedef enum logic [2:0] {
    SRX_OP_NONE,
    SRX_OP_ROTATE_RIGHT_CARRY,
    SRX_OP_SUB_ACC_FROM_REG,
    SRX_OP_SUB_ACC_FROM_LITERAL,
    SRX_OP_SUB_ACC_BORROW_FROM_REG,
    SRX_OP_NIBBLE_EXCHANGE,
    SRX_OP_SLEEP
  } srx_op_e;
endpackage : srx_pkg

// ### srx_subtract.sv
// Subtractor: a - b - borrow with no-borrow flags on the byte and nibble.
// Assumes purely combinational use by srx_exec.
`timescale 1ns/1ps
`include "srx_defines.svh"
module srx_subtract
  import srx_pkg::*;
#(
  parameter int W = `SRX_DATA_W
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         borrow_in,
  // Results
  output logic      [W-1:0] diff,
  output logic              carry_out,
  output logic              nib_carry_out
);
  initial begin
    if (W < 8) $error("srx_subtract: width below 8");
  end

  logic [W:0] full;
  logic [4:0] low;

  // A set extra bit means a borrow left the top; flags are active-low borrow
  always_comb begin
    full          = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, borrow_in};
    low           = {1'b0, a[`SRX_NIB_LO:0]} - {1'b0, b[`SRX_NIB_LO:0]}
                    - {4'h0, borrow_in};
    diff          = full[W-1:0];
    carry_out     = ~full[W];
    nib_carry_out = ~low[4];
  end
endmodule : srx_subtract

// ### srx_exec.sv
// Execution logic for rotate-right through carry, the subtract forms,
// the nibble exchange and the sleep side effects on status and watchdog.
// Assumes the decoder presents one instruction per cycle with op_valid
// and operands already fetched from the register file on the same clock.
`timescale 1ns/1ps
`include "srx_defines.svh"

// Notes on behaviour
// - Seven-bit address; destination 0 is accumulator, 1 the register.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Sleep clears the watchdog count and its prescaler.
// - Sleep clears sleep_entered_bit and sets watchdog_expiry_bit.
// - Register minus accumulator; carry flags mean no borrow; zero too.
// - Literal minus accumulator into accumulator; same flag convention.
// - Register minus accumulator minus inverted carry; flags updated.
// - Nibble exchange swaps high and low nibbles into the destination.
module srx_exec
  import srx_pkg::*;
#(
  parameter int DW = `SRX_DATA_W,
  parameter int AW = `SRX_ADDR_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Instruction from the decoder
  input  wire logic          op_valid,
  input  srx_op_e            op,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic          dest_sel,
  input  wire logic [DW-1:0] literal,
  // Operands from the register file
  input  wire logic [DW-1:0] reg_data,
  input  wire logic [DW-1:0] acc,
  // Accumulator write
  output logic               acc_we,
  output logic      [DW-1:0] acc_wdata,
  // Register file write-back
  output logic               reg_we,
  output logic      [AW-1:0] reg_waddr,
  output logic      [DW-1:0] reg_wdata,
  // Status flags
  output logic               carry,
  output logic               nibble_borrow_not,
  output logic               zero,
  output logic               watchdog_expiry_bit,
  output logic               sleep_entered_bit,
  // Watchdog clear
  output logic [`SRX_WDT_W-1:0] watchdog_count,
  output logic [`SRX_PRE_W-1:0] watchdog_prescale
);
  initial begin
    if (DW != `SRX_DATA_W) $error("srx_exec: data width must be 8");
    if (AW != `SRX_ADDR_W) $error("srx_exec: address width must be 7");
  end

  typedef struct packed {
    logic                   acc_we;
    logic [DW-1:0]          acc_wdata;
    logic                   reg_we;
    logic [AW-1:0]          reg_waddr;
    logic [DW-1:0]          reg_wdata;
    logic                   carry;
    logic                   dc;
    logic                   zero;
    logic                   expiry;
    logic                   sleep_in;
    logic [`SRX_WDT_W-1:0]  wdt;
    logic [`SRX_PRE_W-1:0]  pre;
  } srx_state_s;

  srx_state_s st;
  srx_state_s next_st;

  logic [DW-1:0] sub_a;
  logic          sub_bin;
  logic [DW-1:0] sub_diff;
  logic          sub_c;
  logic          sub_dc;

  // One shared subtractor; the literal form only swaps its first operand
  always_comb begin
    sub_a   = (op == SRX_OP_SUB_ACC_FROM_LITERAL) ? literal
                                                  : reg_data;
    sub_bin = (op == SRX_OP_SUB_ACC_BORROW_FROM_REG) ? ~st.carry
                                                     : 1'b0;
  end

  srx_subtract #(
    .W (DW)
  ) u_sub (
    .a             (sub_a),
    .b             (acc),
    .borrow_in     (sub_bin),
    .diff          (sub_diff),
    .carry_out     (sub_c),
    .nib_carry_out (sub_dc)
  );

  always_comb begin
    logic [DW-1:0] res;
    logic          write;
    res           = `SRX_ZERO8;
    write         = 1'b0;
    next_st       = st;
    next_st.acc_we = 1'b0;
    next_st.reg_we = 1'b0;
    if (op_valid) begin
      case (op)
        SRX_OP_ROTATE_RIGHT_CARRY: begin
          res           = {st.carry, reg_data[`SRX_MSB:1]};
          next_st.carry = reg_data[0];
          write         = 1'b1;
        end
        SRX_OP_SUB_ACC_FROM_REG,
        SRX_OP_SUB_ACC_BORROW_FROM_REG: begin
          res           = sub_diff;
          next_st.carry = sub_c;
          next_st.dc    = sub_dc;
          next_st.zero  = (sub_diff == `SRX_ZERO8);
          write         = 1'b1;
        end
        SRX_OP_SUB_ACC_FROM_LITERAL: begin
          next_st.acc_we    = 1'b1;
          next_st.acc_wdata = sub_diff;
          next_st.carry     = sub_c;
          next_st.dc        = sub_dc;
          next_st.zero      = (sub_diff == `SRX_ZERO8);
        end
        SRX_OP_NIBBLE_EXCHANGE: begin
          res   = {reg_data[`SRX_NIB_LO:0],
                   reg_data[`SRX_MSB:`SRX_NIB_HI]};
          write = 1'b1;
        end
        SRX_OP_SLEEP: begin
          next_st.wdt      = '0;
          next_st.pre      = '0;
          next_st.sleep_in = 1'b0;
          next_st.expiry   = 1'b1;
        end
        default: begin
          write = 1'b0;
        end
      endcase
    end
    // Destination steering for the register-operand forms
    if (write) begin
      if (dest_sel == `SRX_DEST_REG) begin
        next_st.reg_we    = 1'b1;
        next_st.reg_waddr = reg_addr;
        next_st.reg_wdata = res;
      end else begin
        next_st.acc_we    = 1'b1;
        next_st.acc_wdata = res;
      end
    end
  end

  // Status bits come up as after power-on: both active-low bits high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.expiry   <= 1'b1;
      st.sleep_in <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign acc_we              = st.acc_we;
  assign acc_wdata           = st.acc_wdata;
  assign reg_we              = st.reg_we;
  assign reg_waddr           = st.reg_waddr;
  assign reg_wdata           = st.reg_wdata;
  assign carry               = st.carry;
  assign nibble_borrow_not   = st.dc;
  assign zero                = st.zero;
  assign watchdog_expiry_bit = st.expiry;
  assign sleep_entered_bit   = st.sleep_in;
  assign watchdog_count      = st.wdt;
  assign watchdog_prescale   = st.pre;
endmodule : srx_exec

// ### srx_exec_monitor.sv
// Checker for srx_exec, watching its ports only.
// Assumes srx_pkg is compiled first.
`timescale 1ns/1ps
module srx_exec_monitor
  import srx_pkg::*;
(
  input wire logic clk, rst_n, op_valid, dest_sel, acc_we, reg_we, carry,
  input wire logic watchdog_expiry_bit, sleep_entered_bit,
  input srx_op_e op,
  input wire logic [6:0] reg_addr, reg_waddr,
  input wire logic [7:0] literal, reg_data, acc, acc_wdata, reg_wdata,
  input wire logic [7:0] watchdog_prescale,
  input wire logic [15:0] watchdog_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_do(srx_op_e o); op_valid && op == o; endsequence
  chk_sleep_clear: assert property (s_do(SRX_OP_SLEEP)
    |=> watchdog_count == 0 && watchdog_prescale == 0) else $error("wdt");
  chk_sleep_status: assert property (s_do(SRX_OP_SLEEP)
    |=> !sleep_entered_bit && watchdog_expiry_bit) else $error("status");
  chk_rot_carry: assert property (s_do(SRX_OP_ROTATE_RIGHT_CARRY)
    |=> carry == $past(reg_data[0])) else $error("rot carry");
  chk_rot_value: assert property (s_do(SRX_OP_ROTATE_RIGHT_CARRY)
    ##0 dest_sel |=> reg_we && reg_wdata == {$past(carry),
    $past(reg_data[7:1])}) else $error("rot value");
  chk_swap_value: assert property (s_do(SRX_OP_NIBBLE_EXCHANGE)
    ##0 !dest_sel |=> acc_we && acc_wdata == {$past(reg_data[3:0]),
    $past(reg_data[7:4])}) else $error("swap");
  chk_lit_result: assert property (s_do(SRX_OP_SUB_ACC_FROM_LITERAL)
    |=> acc_we && !reg_we && acc_wdata == $past(literal) - $past(acc))
    else $error("literal");
  chk_sub_carry: assert property (s_do(SRX_OP_SUB_ACC_FROM_REG)
    |=> carry == ($past(acc) <= $past(reg_data))) else $error("carry");
  chk_dest_addr: assert property (s_do(SRX_OP_SUB_ACC_FROM_REG)
    ##0 dest_sel |=> reg_we && !acc_we && reg_waddr == $past(reg_addr))
    else $error("dest");
endmodule : srx_exec_monitor
bind srx_exec srx_exec_monitor srx_exec_monitor_i (.*);

// ### srx_regfile_model.sv
// Register-file and accumulator stand-in feeding srx_exec operands.
// Assumes write strobes arrive one cycle after each instruction.
`timescale 1ns/1ps
module srx_regfile_model (
  input  wire logic       clk, acc_we, reg_we,
  input  wire logic [6:0] reg_addr, reg_waddr,
  input  wire logic [7:0] acc_wdata, reg_wdata,
  output logic      [7:0] reg_data, acc
);
  logic [7:0] rf [128];
  logic [7:0] acc_q = 8'h00;
  initial for (int i = 0; i < 128; i++) rf[i] = 8'(i * 37);
  // Forward pending writes so back-to-back ops see fresh operands
  assign acc = acc_we ? acc_wdata : acc_q;
  assign reg_data = (reg_we && reg_waddr == reg_addr) ? reg_wdata
                                                      : rf[reg_addr];
  always @(posedge clk) begin
    if (acc_we) acc_q <= acc_wdata;
    if (reg_we) rf[reg_waddr] <= reg_wdata;
  end
endmodule : srx_regfile_model

// ### cpu_subtract_rotate_swap_exec_tb.sv
// Self-checking bench for srx_exec against a register-file stand-in.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
module cpu_subtract_rotate_swap_exec_tb;
  import srx_pkg::*;
  logic clk = 0, rst_n = 0, op_valid = 0, dest_sel = 0, acc_we, reg_we;
  logic carry, nibble_borrow_not, zero, watchdog_expiry_bit;
  logic sleep_entered_bit, ec = 0, ed = 0, ez = 0;
  srx_op_e op = SRX_OP_NONE;
  logic [6:0] reg_addr = 0, reg_waddr;
  logic [7:0] literal = 0, reg_data, acc, acc_wdata, reg_wdata;
  logic [7:0] watchdog_prescale;
  logic [15:0] watchdog_count;
  int bad_count = 0, compares = 0, cyc = 0;
  srx_exec srx_exec_i (.*);
  srx_regfile_model srx_regfile_model_i (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    bad_count++;
    final_report();
  end
  task automatic cmp(input logic [31:0] got, want);
    compares++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : cmp
  task automatic step(logic v, srx_op_e o, logic [6:0] ad, logic d,
                      logic [7:0] k);
    logic [7:0] r, x;
    logic [8:0] s;
    logic [4:0] n;
    logic b, go, wa, wr;
    op_valid = v; op = o; reg_addr = ad; dest_sel = d; literal = k;
    #1 go = v && o != SRX_OP_NONE;
    r = o == SRX_OP_SUB_ACC_FROM_LITERAL ? k : reg_data;
    b = o == SRX_OP_SUB_ACC_BORROW_FROM_REG && !ec;
    s = {1'b0, r} - acc - b;
    n = {1'b0, r[3:0]} - acc[3:0] - b;
    x = o == SRX_OP_ROTATE_RIGHT_CARRY ? {ec, r[7:1]} :
        o == SRX_OP_NIBBLE_EXCHANGE ? {r[3:0], r[7:4]} : s[7:0];
    wr = go && d && o != SRX_OP_SLEEP && o != SRX_OP_SUB_ACC_FROM_LITERAL;
    wa = go && !wr && o != SRX_OP_SLEEP;
    if (go && o == SRX_OP_ROTATE_RIGHT_CARRY) ec = r[0];
    if (go && o inside {SRX_OP_SUB_ACC_FROM_REG, SRX_OP_SUB_ACC_FROM_LITERAL,
        SRX_OP_SUB_ACC_BORROW_FROM_REG}) {ec, ed, ez} = {!s[8], !n[4], x == 0};
    @(negedge clk);
    cmp({acc_we, reg_we}, {wa, wr});
    if (wa) cmp(acc_wdata, x);
    if (wr) cmp({reg_waddr, reg_wdata}, {ad, x});
    cmp({carry, nibble_borrow_not, zero}, {ec, ed, ez});
    if (go && o == SRX_OP_SLEEP) cmp({watchdog_count, watchdog_prescale,
      watchdog_expiry_bit, sleep_entered_bit}, 26'h2);
  endtask : step
  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'h302e));
    repeat (8) @(negedge clk);
    rst_n = 1;
    cmp({watchdog_expiry_bit, sleep_entered_bit, carry, acc_we}, 4'hc);
    step(1, SRX_OP_SUB_ACC_FROM_LITERAL, 0, 1, 8'h00);
    step(1, SRX_OP_SUB_ACC_BORROW_FROM_REG, 7'h7f, 1, 0);
    step(1, SRX_OP_SLEEP, 0, 0, 0);
    repeat (400) step($urandom_range(7) != 0, srx_op_e'($urandom_range(6)),
      7'($urandom), 1'($urandom), 8'($urandom));
    final_report();
  end
endmodule : cpu_subtract_rotate_swap_exec_tb
